// ===== hw/sfap_top.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
module sfap_top
	import sfap_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic wp_n_pin,
	input wire logic hold_n_pin,
	output logic wp_asserted,
	output logic pause_asserted,
	output logic quad_io_en,
	output logic [1:0] quad_io_hi_data,
	output logic op_go,
	output logic op_reject,
	output logic [23:0] op_start,
	output logic [23:0] op_end
);
	logic [15:0] status_q, status_d;
	logic [23:0] start_q, end_q;
	logic [2:0] result_q, result_d;
	logic go_q, rej_q;
	logic [31:0] rdata_q, rdata_d;
	logic wp_s1_q, wp_s2_q, hold_s1_q, hold_s2_q;

	sfap_prot_if pif ();
	sfap_range u_range (
		.pif(pif)
	);

	function automatic logic hits_range(input logic [23:0] s,
		input logic [23:0] e, input logic [23:0] lo, input logic [23:0] hi);
		hits_range = (s <= hi) && (e >= lo);
	endfunction : hits_range

	function automatic logic inside_range(input logic [23:0] s,
		input logic [23:0] e, input logic [23:0] lo, input logic [23:0] hi);
		inside_range = (s >= lo) && (e <= hi);
	endfunction : inside_range

	wire cmp = status_q[SFAP_CMP_BIT];
	wire qe = status_q[SFAP_QE_BIT];
	wire [2:0] lock_bits = status_q[SFAP_LB_LSB +: 3];
	assign pif.code = status_q[SFAP_BP_LSB +: 3];
	assign pif.sec = status_q[SFAP_SEC_BIT];
	assign pif.tb = status_q[SFAP_TB_BIT];

	wire wr_status = reg_wr && (reg_addr == SFAP_REG_STATUS);
	wire wr_start = reg_wr && (reg_addr == SFAP_REG_OP_START);
	wire wr_end = reg_wr && (reg_addr == SFAP_REG_OP_END);
	wire op_kick = reg_wr && (reg_addr == SFAP_REG_OP_CTRL);
	wire secreg_op = reg_wdata[SFAP_OPC_SECREG_BIT];
	wire [1:0] secreg_idx = reg_wdata[SFAP_OPC_IDX_LSB +: 2];

	// lock bits only ever gain ones; the other fields in SFAP_STATUS_WMASK take the written value, all remaining bits stay zero
	assign status_d = wr_status ? (((reg_wdata[15:0] & SFAP_STATUS_WMASK)
		& ~SFAP_LB_MASK) | ((reg_wdata[15:0] | status_q) & SFAP_LB_MASK))
		: status_q;

	// plain range when complement is clear, its inverse when set
	wire plain_hit = !pif.r_none && (pif.r_all ||
		hits_range(start_q, end_q, pif.r_lo, pif.r_hi));
	wire comp_hit = !pif.r_all && (pif.r_none ||
		!inside_range(start_q, end_q, pif.r_lo, pif.r_hi));
	wire array_hit = cmp ? comp_hit : plain_hit;
	wire bad_span = end_q < start_q;
	// index 0 names no security register, so it is refused too;
	// the padded vector keeps the select in range for every index
	wire [3:0] lock_vec = {lock_bits, 1'b1};
	wire lock_hit = lock_vec[secreg_idx];
	wire refuse = secreg_op ? lock_hit : (bad_span || array_hit);

	assign result_d = op_kick ? {secreg_op && lock_hit, refuse, !refuse}
		: result_q;

	always_comb begin
		case (reg_addr)
			SFAP_REG_STATUS: rdata_d = {16'h0000, status_q};
			SFAP_REG_OP_START: rdata_d = {8'h00, start_q};
			SFAP_REG_OP_END: rdata_d = {8'h00, end_q};
			SFAP_REG_RESULT: rdata_d = {29'h0, result_q};
			default: rdata_d = 32'h00000000;
		endcase
		if (!reg_rd) begin
			rdata_d = 32'h00000000;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			status_q <= SFAP_STATUS_RST;
			start_q <= SFAP_ADDR_RST;
			end_q <= SFAP_ADDR_RST;
			result_q <= SFAP_RESULT_RST;
			go_q <= 1'b0;
			rej_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			status_q <= status_d;
			start_q <= wr_start ? reg_wdata[23:0] : start_q;
			end_q <= wr_end ? reg_wdata[23:0] : end_q;
			result_q <= result_d;
			go_q <= op_kick && !refuse;
			rej_q <= op_kick && refuse;
			rdata_q <= rdata_d;
		end
	end

	// pins are asynchronous to the clock
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
			hold_s1_q <= 1'b1;
			hold_s2_q <= 1'b1;
		end else begin
			wp_s1_q <= wp_n_pin;
			wp_s2_q <= wp_s1_q;
			hold_s1_q <= hold_n_pin;
			hold_s2_q <= hold_s1_q;
		end
	end

	// a strapped pin would force a data bit in quad mode; host must avoid it
	assign wp_asserted = !qe && !wp_s2_q;
	assign pause_asserted = !qe && !hold_s2_q;
	assign quad_io_en = qe;
	assign quad_io_hi_data = qe ? {hold_s2_q, wp_s2_q} : 2'h0;

	assign reg_rdata = rdata_q;
	assign op_go = go_q;
	assign op_reject = rej_q;
	assign op_start = start_q;
	assign op_end = end_q;

	// checks
	property p_lock_sticky;
		@(posedge clock) disable iff (sys_rst)
		$past(lock_bits) != 3'h0 |-> ((lock_bits & $past(lock_bits))
			== $past(lock_bits));
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock bit cleared");

	property p_lock_set;
		@(posedge clock) disable iff (sys_rst)
		wr_status && reg_wdata[SFAP_LB_LSB] |=> lock_bits[0];
	endproperty
	a_lock_set: assert property (p_lock_set)
		else $error("lock bit not set by status write");

	property p_locked_refused;
		@(posedge clock) disable iff (sys_rst)
		op_kick && secreg_op && secreg_idx != 2'h0 &&
			lock_bits[2'(secreg_idx - 2'h1)] |=> op_reject && !op_go;
	endproperty
	a_locked_refused: assert property (p_locked_refused)
		else $error("locked security register accepted");

	property p_qe_read;
		@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == SFAP_REG_STATUS ##1 !$past(wr_status)
			|-> reg_rdata[SFAP_QE_BIT] == $past(qe);
	endproperty
	a_qe_read: assert property (p_qe_read)
		else $error("quad enable readback wrong");

	property p_wp_ctrl;
		@(posedge clock) disable iff (sys_rst)
		!qe && !wp_n_pin ##1 !wp_n_pin ##1 !qe |-> wp_asserted;
	endproperty
	a_wp_ctrl: assert property (p_wp_ctrl)
		else $error("write protect not seen");

	property p_quad_frees_pins;
		@(posedge clock) disable iff (sys_rst)
		quad_io_en |-> !wp_asserted && !pause_asserted && quad_io_hi_data
			== {$past(hold_n_pin, 2), $past(wp_n_pin, 2)};
	endproperty
	a_quad_frees_pins: assert property (p_quad_frees_pins)
		else $error("control pin active in quad mode");

	property p_code0_open;
		@(posedge clock) disable iff (sys_rst)
		op_kick && !secreg_op && !cmp && pif.code == 3'h0 && !bad_span
			|=> op_go;
	endproperty
	a_code0_open: assert property (p_code0_open)
		else $error("unprotected op refused");

	property p_all_closed;
		@(posedge clock) disable iff (sys_rst)
		op_kick && !secreg_op && (cmp ? pif.code == 3'h0
			: pif.code[2:1] == 2'h3) |=> op_reject;
	endproperty
	a_all_closed: assert property (p_all_closed)
		else $error("fully protected array accepted op");

	property p_one_answer;
		@(posedge clock) disable iff (sys_rst)
		op_kick |=> (op_go ^ op_reject) ##1 !op_go && !op_reject
			|| $past(op_kick);
	endproperty
	a_one_answer: assert property (p_one_answer)
		else $error("op answer not exactly one pulse");

	property p_bad_span;
		@(posedge clock) disable iff (sys_rst)
		op_kick && !secreg_op && bad_span |=> op_reject;
	endproperty
	a_bad_span: assert property (p_bad_span)
		else $error("reversed span accepted");

	c_go: cover property (@(posedge clock) disable iff (sys_rst) op_go);
	c_rej: cover property (@(posedge clock) disable iff (sys_rst)
		op_reject && cmp);
	c_lock: cover property (@(posedge clock) disable iff (sys_rst)
		lock_bits == 3'h7);
endmodule : sfap_top

// ===== inc/sfap_pkg.sv
package sfap_pkg;
	// register indexes on the plain register port
	localparam logic [3:0] SFAP_REG_STATUS = 4'h0;
	localparam logic [3:0] SFAP_REG_OP_START = 4'h1;
	localparam logic [3:0] SFAP_REG_OP_END = 4'h2;
	localparam logic [3:0] SFAP_REG_OP_CTRL = 4'h3;
	localparam logic [3:0] SFAP_REG_RESULT = 4'h4;
	// status word layout
	localparam int SFAP_BP_LSB = 2;
	localparam int SFAP_TB_BIT = 5;
	localparam int SFAP_SEC_BIT = 6;
	localparam int SFAP_QE_BIT = 9;
	localparam int SFAP_LB_LSB = 11;
	localparam int SFAP_CMP_BIT = 14;
	localparam logic [15:0] SFAP_STATUS_WMASK = 16'h427c;
	localparam logic [15:0] SFAP_LB_MASK = 16'h3800;
	localparam logic [15:0] SFAP_STATUS_RST = 16'h0000;
	// op control layout
	localparam int SFAP_OPC_SECREG_BIT = 0;
	localparam int SFAP_OPC_IDX_LSB = 1;
	// result layout
	localparam int SFAP_RES_GO_BIT = 0;
	localparam int SFAP_RES_REJ_BIT = 1;
	localparam int SFAP_RES_LOCK_BIT = 2;
	localparam logic [2:0] SFAP_RESULT_RST = 3'h0;
	// array geometry
	localparam int SFAP_AW = 24;
	localparam logic [23:0] SFAP_ARRAY_BYTES = 24'h200000;
	localparam logic [23:0] SFAP_BLOCK_BYTES = 24'h010000;
	localparam logic [23:0] SFAP_SECTOR_BYTES = 24'h001000;
	localparam logic [23:0] SFAP_ADDR_RST = 24'h000000;
endpackage : sfap_pkg

// ===== inc/sfap_prot_if.sv
interface sfap_prot_if;
	logic [2:0] code;
	logic sec;
	logic tb;
	logic [23:0] r_lo;
	logic [23:0] r_hi;
	logic r_none;
	logic r_all;
	modport dec (input code, input sec, input tb,
		output r_lo, output r_hi, output r_none, output r_all);
	modport use_side (output code, output sec, output tb,
		input r_lo, input r_hi, input r_none, input r_all);
endinterface : sfap_prot_if

// ===== hw/sfap_range.sv
// decodes the uncomplemented protected range from the block-protect fields
module sfap_range
	import sfap_pkg::*;
(
	sfap_prot_if.dec pif
);
	wire [2:0] sec_shift;
	wire [2:0] blk_shift;
	wire [23:0] size;
	// 10x with small units both mean 32KB
	assign sec_shift = pif.code[2] ? 3'h3 : 3'(pif.code - 3'h1);
	assign blk_shift = 3'(pif.code - 3'h1);
	assign size = pif.sec ? (SFAP_SECTOR_BYTES << sec_shift)
		: (SFAP_BLOCK_BYTES << blk_shift);
	assign pif.r_none = (pif.code == 3'h0);
	assign pif.r_all = (pif.code[2:1] == 2'h3);
	assign pif.r_lo = pif.tb ? 24'h000000 : 24'(SFAP_ARRAY_BYTES - size);
	assign pif.r_hi = pif.tb ? 24'(size - 24'h000001)
		: 24'(SFAP_ARRAY_BYTES - 24'h000001);
endmodule : sfap_range

// ===== tb/sfap_pin_model.sv
module sfap_pin_model (
	input wire logic quad_io_en,
	input wire logic [1:0] ctl_n,
	input wire logic [1:0] io_val,
	output logic wp_n_pin,
	output logic hold_n_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// pins always driven by logic, never strapped, so quad mode is safe
	assign wp_n_pin = quad_io_en ? io_val[0] : ctl_n[0];
	assign hold_n_pin = quad_io_en ? io_val[1] : ctl_n[1];
endmodule : sfap_pin_model

// ===== tb/test_serial_flash_array_protection.sv
module test_serial_flash_array_protection;
	timeunit 1ns;
	timeprecision 1ns;
	import sfap_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic wp_n_pin, hold_n_pin, wp_asserted, pause_asserted, quad_io_en;
	logic [1:0] quad_io_hi_data;
	logic [1:0] ctl_n = 2'h3;
	logic [1:0] io_val = 2'h0;
	logic op_go, op_reject;
	logic [23:0] op_start, op_end;
	int bad_count = 0;
	int num_checks = 0;
	// status, start, end, refused
	logic [64:0] tbl [14] = '{
		{16'h0004, 24'h1f0000, 24'h1fffff, 1'b1},
		{16'h0004, 24'h1e0000, 24'h1effff, 1'b0},
		{16'h0014, 24'h0fffff, 24'h0fffff, 1'b0},
		{16'h0024, 24'h00ffff, 24'h00ffff, 1'b1},
		{16'h0024, 24'h010000, 24'h1fffff, 1'b0},
		{16'h0044, 24'h1fefff, 24'h1fefff, 1'b0},
		{16'h0044, 24'h1ef000, 24'h1ff000, 1'b1},
		{16'h0018, 24'h000000, 24'h000000, 1'b1},
		{16'h4000, 24'h100000, 24'h100000, 1'b1},
		{16'h401c, 24'h000000, 24'h1fffff, 1'b0},
		{16'h4004, 24'h1effff, 24'h1effff, 1'b1},
		{16'h4004, 24'h1f0000, 24'h1fffff, 1'b0},
		{16'h4064, 24'h001000, 24'h001000, 1'b1},
		{16'h4064, 24'h000000, 24'h000fff, 1'b0}};

	always #25 clock = ~clock;

	sfap_pin_model sfap_pin_model_i (.quad_io_en, .ctl_n, .io_val,
		.wp_n_pin, .hold_n_pin);

	sfap_top sfap_top_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .wp_n_pin, .hold_n_pin, .wp_asserted,
		.pause_asserted, .quad_io_en, .quad_io_hi_data, .op_go, .op_reject,
		.op_start, .op_end);

	task end_sim;
		if (bad_count == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task rdc(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rdc

	task op(input logic [23:0] s, input logic [23:0] e,
		input logic [31:0] c, input logic rej);
		wr(SFAP_REG_OP_START, {8'h0, s});
		wr(SFAP_REG_OP_END, {8'h0, e});
		wr(SFAP_REG_OP_CTRL, c);
		#1 chk(32'({op_go, op_reject}), 32'({~rej, rej}));
		chk(32'(op_start), 32'(s));
		chk(32'(op_end), 32'(e));
	endtask : op

	task pins(input logic [4:0] exp);
		repeat (3) @(posedge clock);
		#1 chk(32'({quad_io_en, quad_io_hi_data, wp_asserted,
			pause_asserted}), 32'(exp));
	endtask : pins

	// hang guard: counts as a mismatch
	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		rdc(SFAP_REG_STATUS, 32'h0);
		wr(SFAP_REG_STATUS, 32'h0800);
		rdc(SFAP_REG_STATUS, 32'h0800);
		op(24'h0, 24'h0, 32'h3, 1'b1);
		rdc(SFAP_REG_RESULT, 32'h6);
		op(24'h0, 24'h0, 32'h5, 1'b0);
		rdc(SFAP_REG_RESULT, 32'h1);
		wr(SFAP_REG_STATUS, 32'h0);
		rdc(SFAP_REG_STATUS, 32'h0800);
		wr(SFAP_REG_STATUS, 32'hffffffff);
		rdc(SFAP_REG_STATUS, 32'h7a7c);
		op(24'h0, 24'h0, 32'h7, 1'b1);
		// pins move only at a clock edge, like every other input
		@(posedge clock);
		io_val <= 2'h2;
		ctl_n <= 2'h0;
		pins(5'b11000);
		wr(SFAP_REG_STATUS, 32'h0);
		pins(5'b00011);
		for (int i = 0; i < 14; i++) begin
			wr(SFAP_REG_STATUS, {16'h0, tbl[i][64:49]});
			op(tbl[i][48:25], tbl[i][24:1], 32'h0, tbl[i][0]);
		end
		wr(SFAP_REG_STATUS, 32'h0);
		op(24'h000000, 24'h1fffff, 32'h0, 1'b0);
		op(24'h000100, 24'h0000ff, 32'h0, 1'b1);
		rdc(SFAP_REG_OP_START, 32'h100);
		rdc(SFAP_REG_OP_END, 32'hff);
		rdc(SFAP_REG_RESULT, 32'h2);
		end_sim();
	end
endmodule : test_serial_flash_array_protection
